// ==== hw/mmio_reset_bank.sv ====
// Register bank of the accelerator: reset values per reset kind and write protection.
// Assumes one request per cycle on reg_req, answer one cycle later; resets arrive synchronous.
`timescale 1ns/100ps
`default_nettype none
module mmio_reset_bank
    import mmio_reset_pkg::*;
#(
    parameter int          NUM_VEC        = 4,
    parameter int          NUM_IMS        = 4,
    parameter logic [7:0]  TOTAL_RDBUF    = 8'h20,
    parameter logic [31:0] SUPPORTED_OPERATION_MASK_VALUE    = 32'h0000_00FF,
    parameter logic [31:0] GEN_CAP_VALUE  = 32'h8000_0000,
    parameter logic [31:0] TABLE_OFFSETS  = 32'h0080_0020,
    parameter logic [31:0] FIXED_GEN_CFG  = 32'h0000_0010,
    parameter logic [31:0] FIXED_WQ_CFG   = 32'h0000_0001,
    parameter logic [31:0] FIXED_GRP_CFG  = 32'h0000_0010
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        warm_rst_n,
    input  wire logic        flr_rst_n,
    input  wire logic        sw_rst_n,
    input  wire reg_req_s    reg_req,
    output var  reg_rsp_s    reg_rsp
);
    // Entry decode assumes every table fits in its 256-byte window
    if (NUM_VEC < 1 || NUM_VEC > 16 || NUM_IMS < 1 || NUM_IMS > 16) begin : g_bad_size
        $error("Table sizes must lie between 1 and 16");
    end

    // Any hard reset returns every register to its reset value; software reset spares the command group
    wire any_rst  = !rst_n || !warm_rst_n || !flr_rst_n || !sw_rst_n;
    wire hard_rst = !rst_n || !warm_rst_n || !flr_rst_n;
    wire cfg_sup  = GEN_CAP_VALUE[CAP_CFG_SUPPORT_BIT];

    logic [31:0] gen_cfg, gen_ctrl, gen_sts, int_cause, evl_cfg, cmd_param, idp, idb, msix_perm, msix_pba;
    logic [31:0] wq_cfg, grp_cfg, cmd, cmd_sts, sw_err, evl_sts;
    logic [31:0] msix_data [NUM_VEC];
    logic [31:0] msix_addr [NUM_VEC];
    logic        msix_mask [NUM_VEC];
    logic [31:0] ims_data  [NUM_IMS];
    logic [63:0] ims_addr  [NUM_IMS];
    logic        ims_mask  [NUM_IMS];
    logic [19:0] ims_process_space_id [NUM_IMS];
    logic [2:0]  ims_flags [NUM_IMS];

    wire wr = reg_req.valid && reg_req.write;
    wire [15:0] a = reg_req.addr;
    wire dev_disabled = gen_sts[GEN_STS_STATE_LSB +: 2] == DEV_DISABLED;
    wire cfg_wr_ok = dev_disabled;

    // Reset values depend on configuration support
    wire [31:0] gen_cfg_rst = cfg_sup ? {24'h0, TOTAL_RDBUF} << GEN_CFG_RDBUF_LSB : FIXED_GEN_CFG;
    wire [31:0] grp_cfg_rst = cfg_sup ? {24'h0, TOTAL_RDBUF} << GRP_CFG_RDBUF_LSB : FIXED_GRP_CFG;
    wire [31:0] wq_cfg_rst  = cfg_sup ? SUPPORTED_OPERATION_MASK_VALUE : FIXED_WQ_CFG;

    always_ff @(posedge clk) begin
        if (any_rst) begin
            gen_ctrl  <= ZERO_WORD;
            gen_sts   <= ZERO_WORD;
            int_cause <= ZERO_WORD;
            evl_cfg   <= ZERO_WORD;
            cmd_param <= ZERO_WORD;
            idp       <= ZERO_WORD;
            idb       <= ZERO_WORD;
            msix_perm <= ZERO_WORD;
            msix_pba  <= ZERO_WORD;
            gen_cfg   <= gen_cfg_rst;
            grp_cfg   <= grp_cfg_rst;
            wq_cfg    <= wq_cfg_rst;
        end else if (wr) begin
            if (a == OFF_GEN_CTRL)  gen_ctrl  <= reg_req.wdata;
            if (a == OFF_GEN_STS)   gen_sts   <= reg_req.wdata;
            if (a == OFF_INT_CAUSE) int_cause <= int_cause & ~reg_req.wdata;
            if (a == OFF_CMD_PARAM) cmd_param <= reg_req.wdata;
            if (a == OFF_IDP)       idp       <= reg_req.wdata;
            if (a == OFF_IDB)       idb       <= reg_req.wdata;
            if (a == OFF_MSIX_PERM) msix_perm <= reg_req.wdata;
            if (a == OFF_WQ_CFG && cfg_sup) wq_cfg <= reg_req.wdata;
            if (a == OFF_GEN_CFG && cfg_wr_ok && cfg_sup) gen_cfg <= reg_req.wdata;
            if (a == OFF_GRP_CFG && cfg_wr_ok && cfg_sup) grp_cfg <= reg_req.wdata;
            if (a == OFF_EVL_CFG && cfg_wr_ok) evl_cfg <= reg_req.wdata;
        end
    end

    // Command group survives a software reset so software can read its outcome
    always_ff @(posedge clk) begin
        if (hard_rst) begin
            cmd     <= ZERO_WORD;
            cmd_sts <= ZERO_WORD;
            sw_err  <= ZERO_WORD;
            evl_sts <= ZERO_WORD;
        end else if (wr && sw_rst_n) begin
            if (a == OFF_CMD)     cmd     <= reg_req.wdata;
            if (a == OFF_SW_ERR)  sw_err  <= sw_err & ~reg_req.wdata;
            if (a == OFF_EVL_STS) evl_sts <= reg_req.wdata;
        end
    end

    generate
        for (genvar i = 0; i < NUM_VEC; i++) begin : g_vec
            wire [15:0] base = OFF_MSIX_TBL + 16'(i) * TBL_STRIDE;
            always_ff @(posedge clk) begin
                if (any_rst) begin
                    msix_data[i] <= ZERO_WORD;
                    msix_addr[i] <= MSIX_ADDR_RST;
                    msix_mask[i] <= 1'b1;
                end else if (wr) begin
                    if (a == base)          msix_addr[i] <= reg_req.wdata;
                    if (a == base + 16'h8)  msix_data[i] <= reg_req.wdata;
                    if (a == base + 16'hC)  msix_mask[i] <= reg_req.wdata[ENTRY_MASK_BIT];
                end
            end
        end
        for (genvar j = 0; j < NUM_IMS; j++) begin : g_ims
            wire [15:0] base = OFF_IMS_TBL + 16'(j) * TBL_STRIDE;
            always_ff @(posedge clk) begin
                if (any_rst) begin
                    ims_data[j]  <= ZERO_WORD;
                    ims_addr[j]  <= IMS_ADDR_RST;
                    ims_mask[j]  <= 1'b1;
                    ims_process_space_id[j] <= 20'h00000;
                    ims_flags[j] <= 3'h0;
                end else if (wr) begin
                    if (a == base)         ims_addr[j][31:0]  <= reg_req.wdata;
                    if (a == base + 16'h4) ims_addr[j][63:32] <= reg_req.wdata;
                    if (a == base + 16'h8) ims_data[j]        <= reg_req.wdata;
                    if (a == base + 16'hC) begin
                        ims_mask[j]  <= reg_req.wdata[0];
                        ims_flags[j] <= reg_req.wdata[3:1];
                        ims_process_space_id[j] <= reg_req.wdata[31:12];
                    end
                end
            end
        end
    endgenerate

    // Read decode
    logic [31:0] rd;
    logic        hit;
    always_comb begin
        rd  = ZERO_WORD;
        hit = 1'b1;
        case (a)
            OFF_VERSION:    rd = {16'h0, VER_MAJOR, VER_MINOR};
            OFF_GEN_CAP:    rd = GEN_CAP_VALUE;
            OFF_TABLE_OFFS: rd = TABLE_OFFSETS;
            OFF_SUPPORTED_OPERATION_MASK:      rd = SUPPORTED_OPERATION_MASK_VALUE;
            OFF_GEN_CFG:    rd = gen_cfg;
            OFF_GEN_CTRL:   rd = gen_ctrl;
            OFF_GEN_STS:    rd = gen_sts;
            OFF_INT_CAUSE:  rd = int_cause;
            OFF_CMD:        rd = cmd;
            OFF_CMD_STS:    rd = cmd_sts;
            OFF_SW_ERR:     rd = sw_err;
            OFF_EVL_CFG:    rd = evl_cfg;
            OFF_EVL_STS:    rd = evl_sts;
            OFF_CMD_PARAM:  rd = cmd_param;
            OFF_IDP:        rd = idp;
            OFF_IDB:        rd = idb;
            OFF_MSIX_PERM:  rd = msix_perm;
            OFF_MSIX_PBA:   rd = msix_pba;
            OFF_WQ_CFG:     rd = wq_cfg;
            OFF_GRP_CFG:    rd = grp_cfg;
            default:        hit = 1'b0;
        endcase
        for (int k = 0; k < NUM_VEC; k++) begin
            if (a == OFF_MSIX_TBL + 16'(k) * TBL_STRIDE)         begin rd = msix_addr[k]; hit = 1'b1; end
            if (a == OFF_MSIX_TBL + 16'(k) * TBL_STRIDE + 16'h8) begin rd = msix_data[k]; hit = 1'b1; end
            if (a == OFF_MSIX_TBL + 16'(k) * TBL_STRIDE + 16'hC) begin rd = {31'h0, msix_mask[k]}; hit = 1'b1; end
        end
        for (int k = 0; k < NUM_IMS; k++) begin
            if (a == OFF_IMS_TBL + 16'(k) * TBL_STRIDE)         begin rd = ims_addr[k][31:0]; hit = 1'b1; end
            if (a == OFF_IMS_TBL + 16'(k) * TBL_STRIDE + 16'h4) begin rd = ims_addr[k][63:32]; hit = 1'b1; end
            if (a == OFF_IMS_TBL + 16'(k) * TBL_STRIDE + 16'h8) begin rd = ims_data[k]; hit = 1'b1; end
            if (a == OFF_IMS_TBL + 16'(k) * TBL_STRIDE + 16'hC) begin
                rd  = {ims_process_space_id[k], 8'h00, ims_flags[k], ims_mask[k]};
                hit = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rsp <= '0;
        end else begin
            reg_rsp.valid <= reg_req.valid;
            reg_rsp.rdata <= (reg_req.valid && !reg_req.write) ? rd : ZERO_WORD;
            reg_rsp.error <= reg_req.valid && !hit;
        end
    end

    // Assertions
    property p_version_ro;
        @(posedge clk) disable iff (!rst_n)
        reg_req.valid && !reg_req.write && a == OFF_VERSION |=> reg_rsp.rdata == {16'h0, VER_MAJOR, VER_MINOR};
    endproperty
    a_version_ro: assert property (p_version_ro) else $error("Version read wrong");

    property p_general_capabilities_fixed;
        @(posedge clk) reg_req.valid && !reg_req.write && a == OFF_GEN_CAP && rst_n |=> reg_rsp.rdata == GEN_CAP_VALUE;
    endproperty
    a_general_capabilities_fixed: assert property (p_general_capabilities_fixed) else $error("Capability changed");

    property p_ctrl_clear;
        @(posedge clk) any_rst |=> gen_ctrl == ZERO_WORD && msix_perm == ZERO_WORD;
    endproperty
    a_ctrl_clear: assert property (p_ctrl_clear) else $error("Control not cleared");

    property p_wq_reset;
        @(posedge clk) any_rst && cfg_sup |=> wq_cfg == SUPPORTED_OPERATION_MASK_VALUE;
    endproperty
    a_wq_reset: assert property (p_wq_reset) else $error("Queue enables wrong after reset");

    property p_cmd_kept;
        @(posedge clk) !sw_rst_n && !hard_rst |=> $stable(cmd) && $stable(sw_err);
    endproperty
    a_cmd_kept: assert property (p_cmd_kept) else $error("Command lost on software reset");

    property p_msix_mask;
        @(posedge clk) any_rst |=> msix_mask[0] && msix_data[0] == ZERO_WORD;
    endproperty
    a_msix_mask: assert property (p_msix_mask) else $error("Vector entry reset wrong");

    property p_ims_reset;
        @(posedge clk) any_rst |=> ims_addr[0] == IMS_ADDR_RST && ims_mask[0] && ims_flags[0] == 3'h0;
    endproperty
    a_ims_reset: assert property (p_ims_reset) else $error("Storage entry reset wrong");

    property p_fixed_cfg;
        @(posedge clk) any_rst && !cfg_sup |=> gen_cfg == FIXED_GEN_CFG && grp_cfg == FIXED_GRP_CFG;
    endproperty
    a_fixed_cfg: assert property (p_fixed_cfg) else $error("Fixed configuration missing");

    property p_cfg_locked;
        @(posedge clk) disable iff (any_rst)
        !dev_disabled |=> $stable(gen_cfg) && $stable(grp_cfg) && $stable(evl_cfg);
    endproperty
    a_cfg_locked: assert property (p_cfg_locked) else $error("Config written while enabled");

    property p_rdbuf;
        @(posedge clk) any_rst && cfg_sup |=> gen_cfg[GEN_CFG_RDBUF_LSB +: 8] == TOTAL_RDBUF;
    endproperty
    a_rdbuf: assert property (p_rdbuf) else $error("Read buffers not at total");

endmodule : mmio_reset_bank
`default_nettype wire

// ==== hw/mmio_reset_pkg.sv ====
// Package for the accelerator register bank: offsets, field layouts and reset values.
// Assumes a single clock domain and a simple word-wide register port.
`default_nettype none
package mmio_reset_pkg;

    typedef enum logic [1:0] {
        RST_POWER_ON,
        RST_WARM,
        RST_FUNCTION,
        RST_SOFTWARE
    } reset_kind_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
        logic        error;
    } reg_rsp_s;

    // Byte offsets
    localparam logic [15:0] OFF_VERSION      = 16'h0000;
    localparam logic [15:0] OFF_GEN_CAP      = 16'h0010;
    localparam logic [15:0] OFF_TABLE_OFFS   = 16'h0060;
    localparam logic [15:0] OFF_SUPPORTED_OPERATION_MASK        = 16'h0070;
    localparam logic [15:0] OFF_GEN_CFG      = 16'h0080;
    localparam logic [15:0] OFF_GEN_CTRL     = 16'h0088;
    localparam logic [15:0] OFF_GEN_STS      = 16'h0090;
    localparam logic [15:0] OFF_INT_CAUSE    = 16'h0098;
    localparam logic [15:0] OFF_CMD          = 16'h00A0;
    localparam logic [15:0] OFF_CMD_STS      = 16'h00A8;
    localparam logic [15:0] OFF_SW_ERR       = 16'h00C0;
    localparam logic [15:0] OFF_EVL_CFG      = 16'h00E0;
    localparam logic [15:0] OFF_EVL_STS      = 16'h00F0;
    localparam logic [15:0] OFF_CMD_PARAM    = 16'hE000;
    localparam logic [15:0] OFF_IDP          = 16'h0100;
    localparam logic [15:0] OFF_IDB          = 16'h0108;
    localparam logic [15:0] OFF_MSIX_PERM    = 16'h0110;
    localparam logic [15:0] OFF_MSIX_PBA     = 16'h5000;
    localparam logic [15:0] OFF_WQ_CFG       = 16'h0200;
    localparam logic [15:0] OFF_GRP_CFG      = 16'h0300;
    localparam logic [15:0] OFF_MSIX_TBL     = 16'h4000;
    localparam logic [15:0] OFF_IMS_TBL      = 16'h8000;
    localparam logic [15:0] TBL_STRIDE       = 16'h0010;

    // Version fields
    localparam int          VER_MAJOR_LSB    = 8;
    localparam int          VER_MINOR_LSB    = 0;
    localparam logic [7:0]  VER_MAJOR        = 8'h02;
    localparam logic [7:0]  VER_MINOR        = 8'h01;

    // Capability bits
    localparam int          CAP_CFG_SUPPORT_BIT = 31;
    localparam int          GEN_CFG_RDBUF_LSB   = 0;
    localparam int          GRP_CFG_RDBUF_LSB   = 0;
    localparam int          GEN_STS_STATE_LSB   = 0;
    localparam logic [1:0]  DEV_DISABLED        = 2'h0;

    // Reset values for interrupt tables
    localparam logic [31:0] MSIX_ADDR_RST    = 32'h0000_0000;
    localparam logic [63:0] IMS_ADDR_RST     = 64'h0000_0000_FEE0_0000;
    localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
    localparam int          ENTRY_MASK_BIT   = 0;

endpackage : mmio_reset_pkg
`default_nettype wire

// ==== tb/accelerator_mmio_reset_values_tb.sv ====
// Self-checking testbench for the accelerator register bank.
// Assumes the bank answers one cycle after a request and that all resets are synchronous.
`timescale 1ns/100ps
`default_nettype none
module accelerator_mmio_reset_values_tb
    import mmio_reset_pkg::*;
;
    localparam logic [7:0]  RDBUF  = 8'h20;
    localparam logic [31:0] SUPPORTED_OPERATION_MASK  = 32'h0000_00FF;
    localparam logic [31:0] GENERAL_CAPABILITIES = 32'h8000_0000;
    localparam logic [31:0] TBLOFF = 32'h0080_0020;
    localparam int          NVEC   = 4;
    localparam int          NIMS   = 4;
    localparam logic [31:0] FIX_GEN = 32'h0000_0010;
    localparam logic [31:0] FIX_WQ  = 32'h0000_0001;
    localparam logic [31:0] FIX_GRP = 32'h0000_0010;

    logic        clk;
    logic        rst_n;
    logic        warm_rst_n;
    logic        flr_rst_n;
    logic        sw_rst_n;
    reg_req_s    reg_req;
    reg_rsp_s    reg_rsp;
    reg_rsp_s    fix_rsp;
    logic [31:0] rd_data;
    logic        rd_err;
    int          n_fail;
    int          checks;
    logic [15:0] zero_offs [9] = '{OFF_GEN_CTRL, OFF_GEN_STS, OFF_INT_CAUSE, OFF_MSIX_PBA, OFF_MSIX_PERM,
                                   OFF_EVL_CFG, OFF_CMD_PARAM, OFF_IDP, OFF_IDB};
    logic [15:0] prot_offs [3] = '{OFF_GEN_CFG, OFF_GRP_CFG, OFF_EVL_CFG};

    mmio_reset_bank #(.TOTAL_RDBUF(RDBUF), .SUPPORTED_OPERATION_MASK_VALUE(SUPPORTED_OPERATION_MASK), .GEN_CAP_VALUE(GENERAL_CAPABILITIES),
                      .TABLE_OFFSETS(TBLOFF), .NUM_VEC(NVEC), .NUM_IMS(NIMS)) u_mmio_reset_bank (
        .clk        (clk),
        .rst_n      (rst_n),
        .warm_rst_n (warm_rst_n),
        .flr_rst_n  (flr_rst_n),
        .sw_rst_n   (sw_rst_n),
        .reg_req    (reg_req),
        .reg_rsp    (reg_rsp)
    );

    // Same bank without configuration support, fed the same requests
    if (1) begin : g_fixed
        mmio_reset_bank #(.GEN_CAP_VALUE(ZERO_WORD), .FIXED_GEN_CFG(FIX_GEN), .FIXED_WQ_CFG(FIX_WQ),
                          .FIXED_GRP_CFG(FIX_GRP), .NUM_VEC(NVEC), .NUM_IMS(NIMS)) u_mmio_reset_bank (
            .clk        (clk),
            .rst_n      (rst_n),
            .warm_rst_n (warm_rst_n),
            .flr_rst_n  (flr_rst_n),
            .sw_rst_n   (sw_rst_n),
            .reg_req    (reg_req),
            .reg_rsp    (fix_rsp)
        );
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic print_verdict;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // Request held for one full cycle; answer awaited with a bounded count
    task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(negedge clk);
        reg_req = '{valid: 1'b1, write: w, addr: a, wdata: d};
        @(negedge clk);
        reg_req.valid = 1'b0;
        while (reg_rsp.valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (reg_rsp.valid !== 1'b1) begin
            $display("Error rsp_valid expected 1 seen %b", reg_rsp.valid);
            n_fail++;
            print_verdict();
        end else begin
            rd_data = reg_rsp.rdata;
            rd_err  = reg_rsp.error;
        end
    endtask : access

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0000_0000);
        checks++;
        if (rd_data !== exp || rd_err !== 1'b0) begin
            $display("Error reg_%h expected %h seen %h err %b", a, exp, rd_data, rd_err);
            n_fail++;
        end
    endtask : rd_chk

    // One reset kind asserted for a single edge: 0 warm, 1 function, 2 software, 3 power-on
    task automatic pulse(input int k);
        @(negedge clk);
        case (k)
            0: warm_rst_n = 1'b0;
            1: flr_rst_n = 1'b0;
            2: sw_rst_n = 1'b0;
            default: rst_n = 1'b0;
        endcase
        @(negedge clk);
        {rst_n, warm_rst_n, flr_rst_n, sw_rst_n} = 4'hF;
    endtask : pulse

    task automatic t_fixed;
        rd_chk(OFF_VERSION, {16'h0000, VER_MAJOR, VER_MINOR});
        access(1'b1, OFF_VERSION, 32'hFFFF_FFFF);
        rd_chk(OFF_VERSION, {16'h0000, VER_MAJOR, VER_MINOR});
        rd_chk(OFF_GEN_CAP, GENERAL_CAPABILITIES);
        access(1'b1, OFF_GEN_CAP, 32'h0000_0000);
        rd_chk(OFF_GEN_CAP, GENERAL_CAPABILITIES);
        rd_chk(OFF_SUPPORTED_OPERATION_MASK, SUPPORTED_OPERATION_MASK);
        rd_chk(OFF_TABLE_OFFS, TBLOFF);
    endtask : t_fixed

    task automatic t_init;
        rd_chk(OFF_GEN_CFG, {24'h000000, RDBUF});
        rd_chk(OFF_GRP_CFG, {24'h000000, RDBUF});
        rd_chk(OFF_WQ_CFG, SUPPORTED_OPERATION_MASK);
        foreach (zero_offs[i]) rd_chk(zero_offs[i], ZERO_WORD);
        rd_chk(OFF_CMD, ZERO_WORD);
        rd_chk(OFF_CMD_STS, ZERO_WORD);
        rd_chk(OFF_SW_ERR, ZERO_WORD);
        rd_chk(OFF_EVL_STS, ZERO_WORD);
        for (int k = 0; k < NVEC; k++) begin
            rd_chk(OFF_MSIX_TBL + 16'(k) * TBL_STRIDE, MSIX_ADDR_RST);
            rd_chk(OFF_MSIX_TBL + 16'(k) * TBL_STRIDE + 16'h0008, ZERO_WORD);
            rd_chk(OFF_MSIX_TBL + 16'(k) * TBL_STRIDE + 16'h000C, 32'h0000_0001);
        end
        for (int k = 0; k < NIMS; k++) begin
            rd_chk(OFF_IMS_TBL + 16'(k) * TBL_STRIDE, IMS_ADDR_RST[31:0]);
            rd_chk(OFF_IMS_TBL + 16'(k) * TBL_STRIDE + 16'h0004, IMS_ADDR_RST[63:32]);
            rd_chk(OFF_IMS_TBL + 16'(k) * TBL_STRIDE + 16'h0008, ZERO_WORD);
            rd_chk(OFF_IMS_TBL + 16'(k) * TBL_STRIDE + 16'h000C, 32'h0000_0001);
        end
    endtask : t_init

    // Writes land while Disabled, then bounce once the state field leaves Disabled
    task automatic t_protect;
        foreach (prot_offs[i]) begin
            access(1'b1, prot_offs[i], 32'h0000_0011);
            rd_chk(prot_offs[i], 32'h0000_0011);
        end
        access(1'b1, OFF_GEN_STS, 32'h0000_0001);
        foreach (prot_offs[i]) begin
            access(1'b1, prot_offs[i], 32'h0000_0022);
            rd_chk(prot_offs[i], 32'h0000_0011);
        end
    endtask : t_protect

    task automatic t_resets;
        for (int k = 0; k < 4; k++) begin
            access(1'b1, OFF_CMD, 32'h0000_00A5);
            access(1'b1, OFF_GEN_STS, 32'h0000_0001);
            access(1'b1, OFF_GEN_CTRL, 32'h0000_0001);
            access(1'b1, OFF_WQ_CFG, ZERO_WORD);
            access(1'b1, OFF_MSIX_TBL + 16'h000C, ZERO_WORD);
            access(1'b1, OFF_IMS_TBL, ZERO_WORD);
            access(1'b1, OFF_EVL_STS, 32'h0000_005A);
            pulse(k);
            rd_chk(OFF_WQ_CFG, SUPPORTED_OPERATION_MASK);
            rd_chk(OFF_IMS_TBL, IMS_ADDR_RST[31:0]);
            rd_chk(OFF_EVL_STS, (k == 2) ? 32'h0000_005A : ZERO_WORD);
            rd_chk(OFF_CMD, (k == 2) ? 32'h0000_00A5 : ZERO_WORD);
            rd_chk(OFF_GEN_STS, ZERO_WORD);
            rd_chk(OFF_GEN_CTRL, ZERO_WORD);
            rd_chk(OFF_GEN_CFG, {24'h000000, RDBUF});
            rd_chk(OFF_VERSION, {16'h0000, VER_MAJOR, VER_MINOR});
            rd_chk(OFF_MSIX_TBL + 16'h000C, 32'h0000_0001);
        end
    endtask : t_resets

    task automatic t_unmapped;
        access(1'b0, 16'h7000, 32'h0000_0000);
        checks++;
        if (rd_err !== 1'b1 || rd_data !== ZERO_WORD) begin
            $display("Error unmapped_read expected err 1 data 0 seen err %b data %h", rd_err, rd_data);
            n_fail++;
        end
    endtask : t_unmapped

    // Both banks answer in the same cycle, so the second one is read alongside
    task automatic fix_chk(input logic [15:0] a, input logic [31:0] exp);
        access(1'b0, a, ZERO_WORD);
        checks++;
        if (fix_rsp.rdata !== exp) begin
            $display("Error fixed_reg_%h expected %h seen %h", a, exp, fix_rsp.rdata);
            n_fail++;
        end
    endtask : fix_chk

    task automatic t_fixed_cfg;
        fix_chk(OFF_GEN_CFG, FIX_GEN);
        fix_chk(OFF_WQ_CFG, FIX_WQ);
        fix_chk(OFF_GRP_CFG, FIX_GRP);
        access(1'b1, OFF_GEN_CFG, 32'h0000_0033);
        access(1'b1, OFF_WQ_CFG, 32'h0000_0033);
        fix_chk(OFF_GEN_CFG, FIX_GEN);
        fix_chk(OFF_WQ_CFG, FIX_WQ);
    endtask : t_fixed_cfg

    initial begin
        n_fail     = 0;
        checks     = 0;
        rst_n      = 1'b0;
        warm_rst_n = 1'b1;
        flr_rst_n  = 1'b1;
        sw_rst_n   = 1'b1;
        reg_req    = '0;
        rd_data    = '0;
        rd_err     = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        t_fixed();
        t_init();
        t_protect();
        t_resets();
        t_unmapped();
        t_fixed_cfg();
        print_verdict();
    end
endmodule : accelerator_mmio_reset_values_tb
`default_nettype wire
